// file: hdl/cfo_fanout.sv
// Command fanout: link word forwarding, clock switchover, board status
`timescale 1ns/10ps
`default_nettype none
`include "cfo_consts.svh"
module cfo_fanout
  import cfo_pkg::*;
#(
  parameter int CMD_CYCLE_WORDS = `CFO_CMD_CYCLE_WORDS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_clk_i,
  input wire logic [19:0] link_word_i,
  input wire logic rx_locked_i,
  input wire logic receiver_status_first_i,
  input wire logic receiver_status_second_i,
  input wire logic run_line_i,
  input wire logic [4:0] board_return_i,
  output logic [18:0] ttl_bus_o,
  output logic frame_marker_o,
  output logic master_clk_o,
  output logic fb_power_ok_o,
  output logic fb_status_first_o,
  output logic fb_status_second_o
);
  localparam int SYNC_W = 30;
  localparam logic [2:0] CYC_LAST = 3'(CMD_CYCLE_WORDS - 1);

  cfo_state_type s_reg;
  cfo_state_type s_next;
  logic [SYNC_W-1:0] sync_q;
  logic lclk_s;
  cfo_word_type word_s;
  logic lock_s;
  logic [1:0] rxst_s;
  logic run_line_s;
  logic [4:0] ret_s;
  logic osc_en;
  logic osc_clk;
  logic osc_marker;
  logic osc_fall;
  logic osc_tick;
  logic lclk_rise;
  logic link_mfall;
  logic req;
  logic run_pulse;
  logic word_tick;
  logic board_err;
  logic fatal;
  logic nonfatal;

  generate
    if (CMD_CYCLE_WORDS < 1 || CMD_CYCLE_WORDS > 8)
    begin : g_chk
      $error("cfo_fanout: CMD_CYCLE_WORDS out of range");
    end
  endgenerate

  function automatic logic adr_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    return a == off;
  endfunction

  // Every link, receiver and board pin passes two flops before any logic sees it; the bus inputs are used directly
  cfo_sync2 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({link_clk_i, link_word_i, rx_locked_i, receiver_status_second_i,
          receiver_status_first_i, run_line_i, board_return_i}),
    .q_o(sync_q)
  );

  // Unplugged cable reads low through the board bias: stays initialize
  assign {lclk_s, word_s, lock_s, rxst_s, run_line_s, ret_s} = sync_q;

  // Oscillator runs only in the pre-switchover states, if enabled
  cfo_osc_gen u_osc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(osc_en),
    .clk_o(osc_clk),
    .marker_o(osc_marker),
    .fall_o(osc_fall),
    .tick_o(osc_tick)
  );

  // Event decode from the sampled link and the bus
  assign lclk_rise = lclk_s & ~s_reg.lclk_prev;
  assign link_mfall = lclk_rise & s_reg.word.marker & ~word_s.marker;
  assign req = wb_cyc_i & wb_stb_i;
  assign run_pulse = req & ~s_reg.ack & wb_we_i & wb_sel_i[0] &
                     adr_hit(wb_adr_i, `CFO_ADR_CTRL) &
                     wb_dat_i[`CFO_CTRL_RUN];
  assign word_tick = (s_reg.mode == CFO_ST_RUN) ? lclk_rise : osc_tick;

  // Error classes; the code bits are never interpreted
  assign board_err = ~ret_s[`CFO_RET_ERR_BIT] & s_reg.err_inc;
  assign fatal = board_err & s_reg.err_fatal;
  assign nonfatal = board_err & ~s_reg.err_fatal;

  // Next-state logic for the whole block
  always_comb
  begin
    s_next = s_reg;
    // Bus slave: one-cycle ack, unmapped reads return zero
    s_next.ack = 1'b0;
    s_next.rdat = '0;
    if (req && !s_reg.ack)
    begin
      s_next.ack = 1'b1;
      if (wb_we_i && wb_sel_i[0] && adr_hit(wb_adr_i, `CFO_ADR_CTRL))
      begin
        s_next.clk_en = wb_dat_i[`CFO_CTRL_CLK_EN];
        s_next.err_inc = wb_dat_i[`CFO_CTRL_ERR_INC];
        s_next.err_fatal = wb_dat_i[`CFO_CTRL_ERR_FATAL];
      end
      if (!wb_we_i)
      begin
        if (adr_hit(wb_adr_i, `CFO_ADR_CTRL))
        begin
          s_next.rdat[`CFO_CTRL_CLK_EN] = s_reg.clk_en;
          s_next.rdat[`CFO_CTRL_ERR_INC] = s_reg.err_inc;
          s_next.rdat[`CFO_CTRL_ERR_FATAL] = s_reg.err_fatal;
        end
        else if (adr_hit(wb_adr_i, `CFO_ADR_STATUS))
        begin
          // Receiver status for polling while lock is pending
          s_next.rdat[8:0] = {s_reg.mode, run_line_s, lock_s,
                              rxst_s[1], rxst_s[0]};
        end
        else if (adr_hit(wb_adr_i, `CFO_ADR_BOARD))
        begin
          s_next.rdat[4:0] = s_reg.board;
        end
      end
    end

    // Link word captured on each sampled link clock rise
    s_next.lclk_prev = lclk_s;
    if (lclk_rise)
      s_next.word = word_s;

    // Switchover sequence; only reset returns to initialize
    case (s_reg.mode)
      CFO_ST_INIT:
      begin
        if (run_pulse || run_line_s)
          s_next.mode = CFO_ST_WAIT_LOCK;
      end
      CFO_ST_WAIT_LOCK:
      begin
        if (lock_s)
          s_next.mode = CFO_ST_WAIT_OSC;
      end
      CFO_ST_WAIT_OSC:
      begin
        // A stopped oscillator has no edge to wait for
        if (osc_fall || !s_reg.clk_en)
          s_next.mode = CFO_ST_WAIT_LINK;
      end
      CFO_ST_WAIT_LINK:
      begin
        if (link_mfall)
          s_next.mode = CFO_ST_RUN;
      end
      CFO_ST_RUN:
      begin
        s_next.mode = CFO_ST_RUN;
      end
      default:
      begin
        s_next.mode = CFO_ST_INIT;
      end
    endcase

    // Board-facing outputs by mode
    case (s_reg.mode)
      CFO_ST_RUN:
      begin
        s_next.mclk = lclk_s;
        s_next.marker = s_reg.word.marker;
        // Whole word below the marker, no field decoded
        s_next.ttl = s_reg.word[`CFO_TTL_WIDTH-1:0];
      end
      CFO_ST_WAIT_LINK:
      begin
        s_next.mclk = 1'b0;
        s_next.marker = 1'b0;
        s_next.ttl = '0;
      end
      default:
      begin
        s_next.mclk = osc_clk;
        s_next.marker = osc_marker;
        s_next.ttl = '0;
      end
    endcase

    // Return status sampled once per command cycle of seven words
    if (word_tick)
    begin
      if (s_reg.frame_cnt == CYC_LAST)
      begin
        s_next.frame_cnt = '0;
        // Bit 0 is the reserved bus bit 20: stored, never acted on
        s_next.board = ret_s;
      end
      else
      begin
        s_next.frame_cnt = s_reg.frame_cnt + 3'h1;
      end
    end

    // Cable status: meaning chosen by the controller's line
    s_next.fb_power_ok = 1'b1;
    if (!run_line_s)
    begin
      s_next.fb_first = rxst_s[0];
      s_next.fb_second = rxst_s[1];
    end
    else
    begin
      s_next.fb_first = fatal;
      s_next.fb_second = nonfatal & ~fatal;
    end
  end

  // Oscillator enable follows the next mode so a stop lands on the
  // very edge that shows the marker fall
  assign osc_en = s_next.clk_en &
                  (s_next.mode == CFO_ST_INIT ||
                   s_next.mode == CFO_ST_WAIT_LOCK ||
                   s_next.mode == CFO_ST_WAIT_OSC);

  // State register; power-up lands in initialize
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      s_reg.mode <= CFO_ST_INIT;
      s_reg.clk_en <= `CFO_CTRL_CLK_EN_RST;
      s_reg.err_inc <= `CFO_CTRL_ERR_INC_RST;
      s_reg.err_fatal <= `CFO_CTRL_ERR_FATAL_RST;
      // Idle bus reads as biased: error high, code 111
      s_reg.board <= `CFO_BOARD_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = s_reg.rdat;
  assign wb_ack_o = s_reg.ack;
  assign ttl_bus_o = s_reg.ttl;
  assign frame_marker_o = s_reg.marker;
  assign master_clk_o = s_reg.mclk;
  assign fb_power_ok_o = s_reg.fb_power_ok;
  assign fb_status_first_o = s_reg.fb_first;
  assign fb_status_second_o = s_reg.fb_second;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_RESET_INIT: assert property (
    $fell(rst_i) |-> s_reg.mode == CFO_ST_INIT)
    else $error("mode not initialize after reset");
  AST_RUN_ENTRY: assert property (
    s_reg.mode == CFO_ST_INIT && (run_pulse || run_line_s)
    |=> s_reg.mode == CFO_ST_WAIT_LOCK)
    else $error("run request not taken");
  AST_LOCK_WAIT: assert property (
    s_reg.mode == CFO_ST_WAIT_LOCK && !lock_s
    |=> s_reg.mode == CFO_ST_WAIT_LOCK)
    else $error("left lock wait without lock");
  AST_OSC_STOP: assert property (
    s_reg.mode == CFO_ST_WAIT_OSC && osc_fall
    |=> s_reg.mode == CFO_ST_WAIT_LINK ##1 !osc_clk [*3])
    else $error("oscillator not stopped at marker fall");
  AST_QUIET: assert property (
    s_reg.mode == CFO_ST_WAIT_LINK
    |=> !master_clk_o && !frame_marker_o && ttl_bus_o == '0)
    else $error("board outputs active during switchover");
  AST_LINK_FALL: assert property (
    s_reg.mode == CFO_ST_WAIT_LINK && link_mfall
    |=> s_reg.mode == CFO_ST_RUN)
    else $error("link marker fall did not enter run");
  AST_TTL_PASS: assert property (
    s_reg.mode == CFO_ST_RUN
    |=> ttl_bus_o == $past(s_reg.word[18:0])
        && frame_marker_o == $past(s_reg.word.marker))
    else $error("link word not forwarded unchanged");
  AST_SAMPLE: assert property (
    word_tick && s_reg.frame_cnt == CYC_LAST
    |=> s_reg.board == $past(ret_s) && s_reg.frame_cnt == 3'h0)
    else $error("return status not sampled at cycle end");
  AST_FB_INIT: assert property (
    !run_line_s |=> fb_status_first_o == $past(rxst_s[0])
                    && fb_status_second_o == $past(rxst_s[1]))
    else $error("receiver status not relayed");
  AST_FB_RUN: assert property (
    run_line_s |=> !(fb_status_first_o && fb_status_second_o))
    else $error("non-fatal reported beside fatal");
  AST_ERR_SEL: assert property (
    run_line_s && !s_reg.err_inc |=> !fb_status_first_o)
    else $error("excluded board error reported");
endmodule
`default_nettype wire

// file: hdl/cfo_consts.svh
// Constants for the command fanout: timing, field positions, offsets
`ifndef CFO_CONSTS_SVH
`define CFO_CONSTS_SVH
// Clock rates in kHz
`define CFO_CLK_FREQ_KHZ 10000
`define CFO_OSC_FREQ_KHZ 53000
// Oscillator half period in clk_i cycles, never below one
`define CFO_OSC_HALF_RAW (`CFO_CLK_FREQ_KHZ / (2 * `CFO_OSC_FREQ_KHZ))
`define CFO_OSC_HALF_CYCLES ((`CFO_OSC_HALF_RAW > 0) ? `CFO_OSC_HALF_RAW : 1)
// Frame layout: seven words, marker high in the last two
`define CFO_FRAME_WORDS 7
`define CFO_MARKER_FIRST 5
`define CFO_CMD_CYCLE_WORDS 7
// Word and bus widths, field positions
`define CFO_WORD_WIDTH 20
`define CFO_MARKER_BIT 19
`define CFO_TTL_WIDTH 19
`define CFO_RET_WIDTH 5
`define CFO_RET_ERR_BIT 4
// Register byte offsets
`define CFO_ADR_CTRL 8'h00
`define CFO_ADR_STATUS 8'h04
`define CFO_ADR_BOARD 8'h08
// Control register fields
`define CFO_CTRL_RUN 0
`define CFO_CTRL_CLK_EN 1
`define CFO_CTRL_ERR_INC 2
`define CFO_CTRL_ERR_FATAL 3
// Reset values
`define CFO_CTRL_CLK_EN_RST 1'b0
`define CFO_CTRL_ERR_INC_RST 1'b0
`define CFO_CTRL_ERR_FATAL_RST 1'b1
`define CFO_BOARD_RST 5'h1e
`endif

// file: hdl/cfo_pkg.sv
// Types shared by the command fanout modules
package cfo_pkg;
  // Switchover sequence, one-hot
  typedef enum logic [4:0] {
    CFO_ST_INIT = 5'h01,
    CFO_ST_WAIT_LOCK = 5'h02,
    CFO_ST_WAIT_OSC = 5'h04,
    CFO_ST_WAIT_LINK = 5'h08,
    CFO_ST_RUN = 5'h10
  } cfo_mode_type;

  // Controller word, bit 19 first
  typedef struct packed {
    logic marker;
    logic pipeline_read_second;
    logic [1:0] read_digitize_quiet_state;
    logic [7:0] bunch_crossing;
    logic first_level_accept;
    logic pipeline_advance;
    logic execute_strobe;
    logic [4:0] board_command;
  } cfo_word_type;

  // Internal oscillator state
  typedef struct packed {
    logic [15:0] cnt;
    logic clk;
    logic [2:0] idx;
    logic fall;
    logic tick;
  } cfo_osc_type;

  // Fanout main state
  typedef struct packed {
    cfo_mode_type mode;
    logic ack;
    logic [31:0] rdat;
    logic clk_en;
    logic err_inc;
    logic err_fatal;
    logic lclk_prev;
    cfo_word_type word;
    logic [18:0] ttl;
    logic marker;
    logic mclk;
    logic [2:0] frame_cnt;
    logic [4:0] board;
    logic fb_power_ok;
    logic fb_first;
    logic fb_second;
  } cfo_state_type;
endpackage

// file: hdl/cfo_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module cfo_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("cfo_sync2: WIDTH must be positive");
    end
  endgenerate

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule
`default_nettype wire

// file: hdl/cfo_osc_gen.sv
// Internal oscillator: master clock and frame marker for initialize mode
`timescale 1ns/10ps
`default_nettype none
`include "cfo_consts.svh"
module cfo_osc_gen
  import cfo_pkg::*;
#(
  parameter int HALF_CYCLES = `CFO_OSC_HALF_CYCLES,
  parameter int FRAME_WORDS = `CFO_FRAME_WORDS,
  parameter int MARKER_FIRST = `CFO_MARKER_FIRST
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  output logic clk_o,
  output logic marker_o,
  output logic fall_o,
  output logic tick_o
);
  localparam logic [15:0] HALF_M1 = 16'(HALF_CYCLES - 1);
  localparam logic [2:0] LAST = 3'(FRAME_WORDS - 1);
  localparam logic [2:0] MFIRST = 3'(MARKER_FIRST);
  cfo_osc_type s_reg;
  cfo_osc_type s_next;

  generate
    if (HALF_CYCLES < 1 || HALF_CYCLES > 65535 || FRAME_WORDS > 8 ||
        MARKER_FIRST < 1 || MARKER_FIRST >= FRAME_WORDS)
    begin : g_chk
      $error("cfo_osc_gen: unsupported parameters");
    end
  endgenerate

  // Word index moves on the falling clock half, so a stop at the
  // marker fall leaves both lines low with no runt pulse
  always_comb
  begin
    s_next = s_reg;
    s_next.fall = 1'b0;
    s_next.tick = 1'b0;
    if (!en_i)
    begin
      s_next.cnt = '0;
      s_next.clk = 1'b0;
      s_next.idx = '0;
    end
    else if (s_reg.cnt == HALF_M1)
    begin
      s_next.cnt = '0;
      s_next.clk = ~s_reg.clk;
      if (s_reg.clk)
      begin
        s_next.tick = 1'b1;
        if (s_reg.idx == LAST)
        begin
          s_next.idx = '0;
          s_next.fall = 1'b1;
        end
        else
        begin
          s_next.idx = s_reg.idx + 3'h1;
        end
      end
    end
    else
    begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign clk_o = s_reg.clk;
  assign marker_o = (s_reg.idx >= MFIRST);
  assign fall_o = s_reg.fall;
  assign tick_o = s_reg.tick;
endmodule
`default_nettype wire

// file: verification/cfo_link_model.sv
// Upstream controller model: link clock, framed words, lock, run line
`timescale 1ns/10ps
`default_nettype none
module cfo_link_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [18:0] data_i,
  output logic link_clk_o,
  output logic [19:0] word_o,
  output logic locked_o,
  output logic run_o
);
  logic [1:0] div_reg;
  logic [2:0] idx_reg;
  logic [3:0] frames_reg;
  // Clock runs free: fill frames keep it going before and after lock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_reg <= 2'h0;
      link_clk_o <= 1'b0;
      idx_reg <= 3'h0;
      frames_reg <= 4'h0;
      word_o <= 20'h0;
    end
    else
    begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3)
        link_clk_o <= ~link_clk_o;
      // New word on the falling edge, steady at the rise
      if (div_reg == 2'h3 && link_clk_o)
      begin
        idx_reg <= (idx_reg == 3'h6) ? 3'h0 : idx_reg + 3'h1;
        word_o <= {(idx_reg >= 3'h4 && idx_reg != 3'h6), data_i};
        if (idx_reg == 3'h6 && frames_reg != 4'hf)
          frames_reg <= frames_reg + 4'h1;
      end
    end
  end
  // Lock after a few fill frames; run line only once locked
  assign locked_o = (frames_reg >= 4'h3);
  assign run_o = go_i & locked_o;
endmodule
`default_nettype wire

// file: verification/test_command_fanout_init_switchover.sv
// Self-checking bench for the command fanout
`timescale 1ns/10ps
`default_nettype none
module test_command_fanout_init_switchover;
  import cfo_pkg::*;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [3:0] s;
    logic [31:0] d;
  } cfo_row_type;
  logic clk_i, rst_i, cyc, stb, we, ack, go, rs1, rs2, lclk, lock, runl;
  logic mrk, mclk, pok, fb1, fb2;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  logic [18:0] data, ttl;
  logic [19:0] word;
  logic [4:0] ret;
  int mismatches, n_tests, cnt_m, cnt_c;
  // Register accesses: reset value, writes and read-backs, unmapped read; d is expected on reads
  cfo_row_type rows [8] = '{
    '{1'b0, 8'h00, 4'hf, 32'h8},
    '{1'b1, 8'h00, 4'hf, 32'he},
    '{1'b0, 8'h00, 4'hf, 32'he},
    '{1'b1, 8'h00, 4'he, 32'h0},
    '{1'b0, 8'h00, 4'hf, 32'he},
    '{1'b1, 8'h04, 4'hf, 32'hffff},
    '{1'b0, 8'h0c, 4'hf, 32'h0},
    '{1'b1, 8'h00, 4'hf, 32'h2}};

  cfo_fanout #(.CMD_CYCLE_WORDS(7)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .link_clk_i(lclk),
    .link_word_i(word), .rx_locked_i(lock),
    .receiver_status_first_i(rs1), .receiver_status_second_i(rs2),
    .run_line_i(runl), .board_return_i(ret), .ttl_bus_o(ttl),
    .frame_marker_o(mrk), .master_clk_o(mclk), .fb_power_ok_o(pok),
    .fb_status_first_o(fb1), .fb_status_second_o(fb2));

  cfo_link_model u_link (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .data_i(data),
    .link_clk_o(lclk), .word_o(word), .locked_o(lock), .run_o(runl));

  // 10 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Classic cycle; an edge with cyc low follows so calls can chain
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [3:0] s, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    // No cycle limit here: only the watchdog ends a wait for ack
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // Poll mode field until run, bounded
  task automatic wait_run();
    int n;
    n = 0;
    do
    begin
      bus(1'b0, 8'h04, 4'hf, 32'h0);
      n++;
    end
    while (rd[8:4] !== 5'h10 && n < 400);
    check(rd[8:4], 5'h10);
  endtask

  // Count marker-high cycles and clock toggles
  task automatic watch(input int n);
    logic prev;
    cnt_m = 0;
    cnt_c = 0;
    prev = mclk;
    repeat (n)
    begin
      @(posedge clk_i);
      if (mrk === 1'b1)
        cnt_m++;
      if (mclk !== prev)
        cnt_c++;
      prev = mclk;
    end
  endtask

  // Hang guard at 10000 cycles, far beyond the roughly one thousand cycles of the run
  initial
  begin
    #1000000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    mismatches = 0;
    n_tests = 0;
    rst_i = 1'b1;
    {cyc, stb, we, go, rs1, rs2} = 6'h0;
    adr = 8'h0;
    sel = 4'h0;
    wdat = 32'h0;
    data = 19'h0;
    ret = 5'h1f;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(pok, 1'b1);
    foreach (rows[i])
    begin
      bus(rows[i].w, rows[i].a, rows[i].s, rows[i].w ? rows[i].d : 32'h0);
      if (!rows[i].w) check(rd, rows[i].d);
    end
    $display("registers done");
    // Oscillator word is two cycles, marker in two of seven
    repeat (4) @(posedge clk_i);
    watch(14);
    check(cnt_c, 14);
    check(cnt_m, 4);
    for (int k = 0; k < 4; k++)
    begin
      rs1 <= k[0];
      rs2 <= k[1];
      repeat (6) @(posedge clk_i);
      check({fb2, fb1}, k[1:0]);
      bus(1'b0, 8'h04, 4'hf, 32'h0);
      check(rd[1:0], k[1:0]);
    end
    ret <= 5'h0b;
    repeat (40) @(posedge clk_i);
    bus(1'b0, 8'h08, 4'hf, 32'h0);
    check(rd[4:0], 5'h0b);
    $display("initialize done");
    go <= 1'b1;
    wait_run();
    // Link word is eight cycles: 14 toggles, marker 16 of 56
    watch(56);
    check(cnt_c, 14);
    check(cnt_m, 16);
    for (int i = 0; i < 19; i++)
    begin
      data <= 19'h1 << i;
      repeat (24) @(posedge clk_i);
      check(ttl, 19'h1 << i);
    end
    $display("switchover done");
    // Error line low; include and fatal select which bit reports it
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, 8'h00, 4'hf, {28'h0, k[1:0], 2'b10});
      repeat (6) @(posedge clk_i);
      check({fb2, fb1}, {k[0] & ~k[1], k[0] & k[1]});
    end
    ret <= 5'h1f;
    repeat (6) @(posedge clk_i);
    check({fb2, fb1}, 2'b00);
    $display("cable done");
    // Reset mid-run drops back to initialize, lock lost
    go <= 1'b0;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    bus(1'b0, 8'h04, 4'hf, 32'h0);
    check(rd[8:4], 5'h01);
    bus(1'b0, 8'h08, 4'hf, 32'h0);
    check(rd[4:0], 5'h1e);
    // Run with board clocks off: no oscillator edge to wait for
    bus(1'b1, 8'h00, 4'hf, 32'h1);
    bus(1'b0, 8'h04, 4'hf, 32'h0);
    check(rd[8:4], 5'h02);
    watch(14);
    check(cnt_c, 0);
    check(cnt_m, 0);
    wait_run();
    $display("software run done");
    end_of_test();
  end
endmodule
`default_nettype wire
